// ---- shared/intc_pkg.sv ----
// Constants, register map and carrier types for the priority interrupt and trap controller
package intc_pkg;

  // ----------------------------------------------------------------
  // Source and vector layout
  // ----------------------------------------------------------------
  localparam int SRC_COUNT      = 72;
  localparam int FIRST_VEC      = 8;
  localparam int TRAP_COUNT     = 5;
  localparam int TRAP_FIRST_VEC = 1;
  localparam int VEC_W          = 7;
  localparam int LVL_W          = 3;
  localparam int ADDR_W         = 24;
  localparam int TDIS_W         = 16;

  localparam logic [LVL_W-1:0]  LVL_MAX        = 3'h7;
  localparam logic [LVL_W-1:0]  LVL_OFF        = 3'h0;
  localparam logic [LVL_W-1:0]  TDIS_BLOCK_LVL = 3'h6;

  // ----------------------------------------------------------------
  // Vector tables
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PRI_BASE      = 24'h000004;
  localparam logic [ADDR_W-1:0] ALT_TRAP_BASE = 24'h000084;
  localparam logic [ADDR_W-1:0] ALT_INT_BASE  = 24'h000104;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CORE_LVL = 8'h04;
  localparam logic [7:0] OFS_TDIS     = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0c;
  localparam logic [7:0] OFS_MASK     = 8'h10;
  localparam logic [7:0] OFS_TRAP     = 8'h14;
  localparam int         OFS_FLAG     = 'h40;
  localparam int         OFS_ENABLE   = 'h60;
  localparam int         OFS_PRIO     = 'h80;

  localparam int NEST_DIS_BIT  = 15;
  localparam int TDIS_ACT_BIT  = 16;
  localparam int PRIO_FIELD_W  = 4;

  // Event bits of the status and mask registers
  localparam int EV_TRAP        = 0;
  localparam int EV_TDIS_END    = 1;
  localparam int EV_LVL_REFUSED = 2;
  localparam int EV_W           = 3;

  localparam logic [EV_W-1:0] STATUS_RST = 3'h0;
  localparam logic [EV_W-1:0] MASK_RST   = 3'h0;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
  } wb_req_t;

  typedef struct packed {
    logic             valid;
    logic [VEC_W-1:0] vec;
    logic [LVL_W-1:0] lvl;
  } offer_t;

endpackage : intc_pkg

// ---- rtl/level_arbiter.sv ----
// Level and natural-order arbiter over all maskable sources
`timescale 1ns/10ps
`default_nettype none

module level_arbiter
  import intc_pkg::*;
#(
  parameter int N = SRC_COUNT
) (
  input  wire logic [N-1:0]            req,
  input  wire logic [N-1:0][LVL_W-1:0] lvl,
  output var offer_t                   best
);

  // ----------------------------------------------------------------
  // Scan from the highest vector down
  // ----------------------------------------------------------------
  // Ties go to the later, lower-numbered hit thanks to >=
  always_comb begin
    best = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && (!best.valid || lvl[i] >= best.lvl)) begin
        best.valid = 1'b1;
        best.lvl   = lvl[i];
        best.vec   = VEC_W'(FIRST_VEC + i);
      end
    end
  end

endmodule : level_arbiter
`default_nettype wire

// ---- rtl/intc_top.sv ----
// Priority interrupt and trap controller with classic Wishbone register slave
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module intc_top
  import intc_pkg::*;
#(
  parameter int NUM_SRC = SRC_COUNT
) (
  input  wire logic                          MCLK,
  input  wire logic                          RST_N,
  input  wire logic                          CYC_I,
  input  wire logic                          STB_I,
  input  wire logic                          WE_I,
  input  wire logic [7:0]                    ADR_I,
  input  wire logic [3:0]                    SEL_I,
  input  wire logic [31:0]                   DAT_I,
  output logic      [31:0]                   DAT_O,
  output logic                               ACK_O,
  output logic                               INT_O,
  input  wire logic [NUM_SRC-1:0]            SRC_EVENT,
  input  wire logic [TRAP_COUNT-1:0]         TRAP_EVENT,
  input  wire logic                          INSTR_DONE,
  input  wire logic                          CORE_ACK,
  input  wire logic                          CORE_RETURN,
  input  wire logic [LVL_W-1:0]              RESTORE_LVL,
  output logic                               REQ,
  output logic      [VEC_W-1:0]              VECTOR,
  output logic      [ADDR_W-1:0]             VEC_ADDR_PRI,
  output logic      [ADDR_W-1:0]             VEC_ADDR_ALT,
  output logic      [LVL_W-1:0]              CORE_LVL
);

  localparam int NFW = (NUM_SRC + 31) / 32;
  localparam int NPW = (NUM_SRC + 7) / 8;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  wb_req_t                    bus;
  offer_t                     int_best;
  offer_t                     trap_best;
  logic [NUM_SRC-1:0]         flag;
  logic [NUM_SRC-1:0]         enable;
  logic [NUM_SRC-1:0][LVL_W-1:0] prio;
  logic [NUM_SRC-1:0]         eligible;
  logic [32*NFW-1:0]          flag_pad;
  logic [32*NFW-1:0]          enable_pad;
  logic [32*NPW-1:0]          prio_pad;
  logic [TRAP_COUNT-1:0]      trap_pend;
  logic                       nest_dis;
  logic [TDIS_W-1:0]          tdis_cnt;
  logic                       tdis_active;
  logic [EV_W-1:0]            status;
  logic [EV_W-1:0]            mask;
  logic [EV_W-1:0]            event_now;
  logic [LVL_W-1:0]           offer_lvl;
  logic                       wr;
  logic                       take;
  logic [31:0]                wmask;
  logic [31:0]                next_rd;
  logic                       lvl_wr;
  logic                       ack_int;
  logic                       ack_trap;
  logic [VEC_W-1:0]           next_vec;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  assign bus   = '{adr: ADR_I, dat: DAT_I, sel: SEL_I, we: WE_I};
  assign take  = CYC_I && STB_I && !ACK_O;
  // Writes land on the edge where the master sees ack, as it expects
  assign wr    = CYC_I && STB_I && bus.we && ACK_O;
  assign wmask = {{8{bus.sel[3]}}, {8{bus.sel[2]}}, {8{bus.sel[1]}}, {8{bus.sel[0]}}};

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0;
    end else begin
      ACK_O <= take;
      if (take) begin
        DAT_O <= next_rd;
      end
    end
  end

  always_comb begin
    next_rd = 32'h0;
    case (bus.adr)
      OFS_CTRL:     next_rd[NEST_DIS_BIT] = nest_dis;
      OFS_CORE_LVL: next_rd[LVL_W-1:0] = CORE_LVL;
      OFS_TDIS: begin
        next_rd[TDIS_W-1:0]  = tdis_cnt;
        next_rd[TDIS_ACT_BIT] = tdis_active;
      end
      OFS_STATUS:   next_rd[EV_W-1:0] = status;
      OFS_MASK:     next_rd[EV_W-1:0] = mask;
      OFS_TRAP:     next_rd[TRAP_COUNT-1:0] = trap_pend;
      default: begin
        // Unmapped addresses read zero and take no write
        for (int w = 0; w < NFW; w++) begin
          if (bus.adr == 8'(OFS_FLAG + 4 * w)) begin
            next_rd = flag_pad[32*w +: 32];
          end
          if (bus.adr == 8'(OFS_ENABLE + 4 * w)) begin
            next_rd = enable_pad[32*w +: 32];
          end
        end
        for (int w = 0; w < NPW; w++) begin
          if (bus.adr == 8'(OFS_PRIO + 4 * w)) begin
            next_rd = prio_pad[32*w +: 32];
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      nest_dis <= 1'b0;
    end else if (wr && bus.adr == OFS_CTRL && bus.sel[NEST_DIS_BIT/8]) begin
      nest_dis <= bus.dat[NEST_DIS_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Per-source flag, enable and priority
  // ----------------------------------------------------------------
  assign flag_pad   = (32*NFW)'(flag);
  assign enable_pad = (32*NFW)'(enable);

  generate
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
      localparam logic [7:0] FADR = 8'(OFS_FLAG + 4 * (i / 32));
      localparam logic [7:0] EADR = 8'(OFS_ENABLE + 4 * (i / 32));
      localparam logic [7:0] PADR = 8'(OFS_PRIO + 4 * (i / 8));
      localparam int         FBIT = i % 32;
      localparam int         PBIT = PRIO_FIELD_W * (i % 8);

      assign prio_pad[PBIT + 32*(i/8) +: PRIO_FIELD_W] = {1'b0, prio[i]};

      // Hardware event wins over a software clear in the same cycle
      always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
          flag[i] <= 1'b0;
        end else if (wr && bus.adr == FADR && bus.sel[FBIT/8]) begin
          flag[i] <= bus.dat[FBIT] | SRC_EVENT[i];
        end else if (SRC_EVENT[i]) begin
          flag[i] <= 1'b1;
        end
      end

      always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
          enable[i] <= 1'b0;
        end else if (wr && bus.adr == EADR && bus.sel[FBIT/8]) begin
          enable[i] <= bus.dat[FBIT];
        end
      end

      always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
          prio[i] <= LVL_OFF;
        end else if (wr && bus.adr == PADR && bus.sel[PBIT/8]) begin
          prio[i] <= bus.dat[PBIT +: LVL_W];
        end
      end

      // Zero never qualifies; level must beat the core level
      assign eligible[i] = flag[i] && enable[i]
                         && (prio[i] != LVL_OFF)
                         && (prio[i] > CORE_LVL)
                         && (!tdis_active || prio[i] > TDIS_BLOCK_LVL);
    end
  endgenerate

  if (32*NPW > PRIO_FIELD_W*NUM_SRC) begin : g_pad
    assign prio_pad[32*NPW-1:PRIO_FIELD_W*NUM_SRC] = '0;
  end

  level_arbiter #(
    .N    (NUM_SRC)
  ) u_arb (
    .req  (eligible),
    .lvl  (prio),
    .best (int_best)
  );

  // ----------------------------------------------------------------
  // Traps
  // ----------------------------------------------------------------
  // Fixed order by vector, never masked by any level
  always_comb begin
    trap_best = '0;
    for (int t = TRAP_COUNT - 1; t >= 0; t--) begin
      if (trap_pend[t]) begin
        trap_best.valid = 1'b1;
        trap_best.vec   = VEC_W'(TRAP_FIRST_VEC + t);
        trap_best.lvl   = LVL_MAX;
      end
    end
  end

  assign ack_trap = CORE_ACK && REQ && (VECTOR < VEC_W'(FIRST_VEC));
  assign ack_int  = CORE_ACK && REQ && (VECTOR >= VEC_W'(FIRST_VEC));

  generate
    for (genvar t = 0; t < TRAP_COUNT; t++) begin : g_trap
      always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
          trap_pend[t] <= 1'b0;
        end else if (TRAP_EVENT[t]) begin
          trap_pend[t] <= 1'b1;
        end else if (ack_trap && VECTOR == VEC_W'(TRAP_FIRST_VEC + t)) begin
          trap_pend[t] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Offer to the core
  // ----------------------------------------------------------------
  assign next_vec = trap_best.valid ? trap_best.vec : int_best.vec;

  // Offer only moves on instruction boundaries, and REQ drops on core ack; a flag cleared while
  // the offer stands is still taken if the core acks first
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      REQ          <= 1'b0;
      VECTOR       <= '0;
      VEC_ADDR_PRI <= '0;
      VEC_ADDR_ALT <= '0;
      offer_lvl    <= LVL_OFF;
    end else if (CORE_ACK) begin
      REQ <= 1'b0;
    end else if (INSTR_DONE) begin
      REQ          <= trap_best.valid || int_best.valid;
      VECTOR       <= next_vec;
      offer_lvl    <= int_best.lvl;
      VEC_ADDR_PRI <= PRI_BASE + ADDR_W'({next_vec, 1'b0});
      VEC_ADDR_ALT <= (trap_best.valid ? ALT_TRAP_BASE : ALT_INT_BASE)
                    + ADDR_W'({next_vec, 1'b0});
    end
  end

  // ----------------------------------------------------------------
  // Core priority level
  // ----------------------------------------------------------------
  assign lvl_wr = wr && bus.adr == OFS_CORE_LVL && bus.sel[0];

  // Core handshake outranks a software write in the same cycle
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      CORE_LVL <= LVL_OFF;
    end else if (ack_int) begin
      CORE_LVL <= nest_dis ? LVL_MAX : offer_lvl;
    end else if (CORE_RETURN) begin
      CORE_LVL <= RESTORE_LVL;
    end else if (lvl_wr && !nest_dis) begin
      CORE_LVL <= bus.dat[LVL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Timed disable
  // ----------------------------------------------------------------
  assign tdis_active = (tdis_cnt != '0);

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      tdis_cnt <= '0;
    end else if (wr && bus.adr == OFS_TDIS && bus.sel[0] && bus.sel[1]) begin
      tdis_cnt <= bus.dat[TDIS_W-1:0];
    end else if (INSTR_DONE && tdis_active) begin
      tdis_cnt <= tdis_cnt - TDIS_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Event status, mask and interrupt line
  // ----------------------------------------------------------------
  always_comb begin
    event_now                 = '0;
    event_now[EV_TRAP]        = |TRAP_EVENT;
    event_now[EV_TDIS_END]    = INSTR_DONE && (tdis_cnt == TDIS_W'(1))
                              && !(wr && bus.adr == OFS_TDIS);
    event_now[EV_LVL_REFUSED] = lvl_wr && nest_dis;
  end

  // A new event wins over the write-one clear of the same bit
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      status <= STATUS_RST;
    end else if (wr && bus.adr == OFS_STATUS && bus.sel[0]) begin
      status <= (status & ~(bus.dat[EV_W-1:0] & wmask[EV_W-1:0])) | event_now;
    end else begin
      status <= status | event_now;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      mask <= MASK_RST;
    end else if (wr && bus.adr == OFS_MASK && bus.sel[0]) begin
      mask <= bus.dat[EV_W-1:0];
    end
  end

  // Registered, so the line trails the status bit by one cycle
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      INT_O <= 1'b0;
    end else begin
      INT_O <= |(status & mask);
    end
  end

endmodule : intc_top
`default_nettype wire

// ---- dv/intc_chk.sv ----
// Port checker for the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module intc_chk
  import intc_pkg::*;
#(
  parameter int NUM_SRC = SRC_COUNT
) (
  input wire logic               MCLK,
  input wire logic               RST_N,
  input wire logic               CYC_I,
  input wire logic               STB_I,
  input wire logic               WE_I,
  input wire logic [7:0]         ADR_I,
  input wire logic [3:0]         SEL_I,
  input wire logic [31:0]        DAT_I,
  input wire logic               ACK_O,
  input wire logic [NUM_SRC-1:0] SRC_EVENT,
  input wire logic               INSTR_DONE,
  input wire logic               CORE_ACK,
  input wire logic               CORE_RETURN,
  input wire logic [LVL_W-1:0]   RESTORE_LVL,
  input wire logic               REQ,
  input wire logic [VEC_W-1:0]   VECTOR,
  input wire logic [ADDR_W-1:0]  VEC_ADDR_PRI,
  input wire logic [ADDR_W-1:0]  VEC_ADDR_ALT,
  input wire logic [LVL_W-1:0]   CORE_LVL
);
  logic nest_off;
  logic bus_wr;
  assign bus_wr = CYC_I && STB_I && ACK_O && WE_I;
  // Shadow of the nesting control, taken at the acked write
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) nest_off <= 1'b0;
    else if (bus_wr && ADR_I == OFS_CTRL && SEL_I[1]) nest_off <= DAT_I[NEST_DIS_BIT];
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // ----
  // Assertions
  // ----
  AST_ACK_LAT: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("bus request not acked next cycle");
  AST_ACK_PULSE: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  AST_OFFER_HOLD: assert property (!INSTR_DONE && !CORE_ACK |=> $stable(REQ) && $stable(VECTOR))
    else $error("offer changed off an instruction boundary");
  AST_ACK_DROP: assert property (CORE_ACK && REQ |=> !REQ)
    else $error("offer still up after core took it");
  AST_LVL_HOLD: assert property (!(CORE_ACK && REQ) && !CORE_RETURN && !bus_wr
    |=> $stable(CORE_LVL))
    else $error("core level moved without cause");
  AST_NEST_RO: assert property (nest_off && bus_wr && ADR_I == OFS_CORE_LVL && !CORE_ACK
    && !CORE_RETURN |=> $stable(CORE_LVL))
    else $error("core level written while nesting off");
  AST_NEST_SEVEN: assert property (nest_off && CORE_ACK && REQ && VECTOR >= FIRST_VEC
    |=> CORE_LVL == LVL_MAX)
    else $error("nesting off but level not forced to max");
  AST_RETURN: assert property (CORE_RETURN && !(CORE_ACK && REQ)
    |=> CORE_LVL == $past(RESTORE_LVL))
    else $error("return did not restore level");
  AST_PRI_ADDR: assert property (REQ |-> VEC_ADDR_PRI == PRI_BASE + ADDR_W'({VECTOR, 1'b0}))
    else $error("primary address wrong");
  AST_ALT_ADDR: assert property (REQ |-> VEC_ADDR_ALT ==
    ((VECTOR < FIRST_VEC) ? ALT_TRAP_BASE : ALT_INT_BASE) + ADDR_W'({VECTOR, 1'b0}))
    else $error("alternate address wrong");
  AST_TRAP_SET: assert property (REQ && VECTOR < FIRST_VEC |-> VECTOR inside {[1:5]})
    else $error("trap vector outside trap set");
  C_TRAP: cover property (CORE_ACK && REQ && VECTOR < FIRST_VEC);
  C_NEST: cover property (nest_off && CORE_ACK && REQ);
  C_HW: cover property (SRC_EVENT != '0);
  C_RET: cover property (CORE_RETURN);
endmodule : intc_chk
bind intc_top intc_chk #(.NUM_SRC(NUM_SRC)) u_chk (
  .MCLK(MCLK), .RST_N(RST_N), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
  .SEL_I(SEL_I), .DAT_I(DAT_I), .ACK_O(ACK_O), .SRC_EVENT(SRC_EVENT),
  .INSTR_DONE(INSTR_DONE), .CORE_ACK(CORE_ACK), .CORE_RETURN(CORE_RETURN),
  .RESTORE_LVL(RESTORE_LVL), .REQ(REQ), .VECTOR(VECTOR), .VEC_ADDR_PRI(VEC_ADDR_PRI),
  .VEC_ADDR_ALT(VEC_ADDR_ALT), .CORE_LVL(CORE_LVL));
`default_nettype wire

// ---- dv/core_model.sv ----
// Processor core model: instruction boundaries, vector take and return
`timescale 1ns/10ps
`default_nettype none
module core_model
  import intc_pkg::*;
(
  input  wire logic             MCLK,
  input  wire logic             RST_N,
  input  wire logic             go,
  input  wire logic [1:0]       cmd,
  input  wire logic [1:0]       slow,
  input  wire logic             REQ,
  input  wire logic [LVL_W-1:0] CORE_LVL,
  output logic                  INSTR_DONE,
  output logic                  CORE_ACK,
  output logic                  CORE_RETURN,
  output logic      [LVL_W-1:0] RESTORE_LVL,
  output logic                  busy
);
  logic [1:0]       pend;
  logic [1:0]       cnt;
  logic [LVL_W-1:0] stk[$];
  assign busy = go || pend != 2'h0;
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pend <= 2'h0;
      cnt <= 2'h0;
      INSTR_DONE <= 1'b0;
      CORE_ACK <= 1'b0;
      CORE_RETURN <= 1'b0;
      RESTORE_LVL <= 3'h0;
    end else begin
      INSTR_DONE <= 1'b0;
      CORE_ACK <= 1'b0;
      CORE_RETURN <= 1'b0;
      if (go) begin
        pend <= cmd;
        cnt <= slow;
      end else if (pend != 2'h0 && cnt != 2'h0) cnt <= cnt - 2'h1;
      else if (pend != 2'h0) begin
        pend <= 2'h0;
        // Boundary only after the instruction ends, so traps wait for it
        if (pend == 2'h1) INSTR_DONE <= 1'b1;
        // Level saved on entry, given back on return
        if (pend == 2'h2 && REQ) begin
          CORE_ACK <= 1'b1;
          stk.push_back(CORE_LVL);
        end
        if (pend == 2'h3) begin
          CORE_RETURN <= 1'b1;
          RESTORE_LVL <= stk.pop_back();
        end
      end
    end
  end
endmodule : core_model
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module tb
  import intc_pkg::*;
;
  logic MCLK, RST_N, CYC_I, STB_I, WE_I, ACK_O, INT_O, REQ, go, busy;
  logic INSTR_DONE, CORE_ACK, CORE_RETURN;
  logic [7:0] ADR_I;
  logic [3:0] SEL_I;
  logic [31:0] DAT_I, DAT_O, q;
  logic [71:0] SRC_EVENT, flg;
  logic [4:0] TRAP_EVENT, trp;
  logic [1:0] cmd, slow;
  logic [2:0] RESTORE_LVL, CORE_LVL;
  logic [6:0] VECTOR;
  logic [23:0] VEC_ADDR_PRI, VEC_ADDR_ALT;
  int err_count, total_checks, pl[72], clvl, lastv, noff, tdis, r, s, k;
  int stk[$];
  intc_top dut (.MCLK(MCLK), .RST_N(RST_N), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .INT_O(INT_O), .SRC_EVENT(SRC_EVENT), .TRAP_EVENT(TRAP_EVENT), .INSTR_DONE(INSTR_DONE),
    .CORE_ACK(CORE_ACK), .CORE_RETURN(CORE_RETURN), .RESTORE_LVL(RESTORE_LVL), .REQ(REQ),
    .VECTOR(VECTOR), .VEC_ADDR_PRI(VEC_ADDR_PRI), .VEC_ADDR_ALT(VEC_ADDR_ALT),
    .CORE_LVL(CORE_LVL));
  core_model core (.MCLK(MCLK), .RST_N(RST_N), .go(go), .cmd(cmd), .slow(slow), .REQ(REQ),
    .CORE_LVL(CORE_LVL), .INSTR_DONE(INSTR_DONE), .CORE_ACK(CORE_ACK),
    .CORE_RETURN(CORE_RETURN), .RESTORE_LVL(RESTORE_LVL), .busy(busy));
  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // ----
  // Bus and core tasks
  // ----
  task automatic wb(logic we, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge MCLK);
    {CYC_I, STB_I, WE_I, ADR_I, DAT_I} <= {2'b11, we, a, d};
    do @(posedge MCLK); while (ACK_O !== 1'b1 && ++n < 20);
    q = DAT_O;
    if (n >= 20) chk("ack", 0, 1);
    {CYC_I, STB_I, WE_I} <= 3'b0;
  endtask : wb
  task automatic rd(logic [7:0] a, logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk("reg", q, e);
  endtask : rd
  task automatic core_do(logic [1:0] c);
    int n;
    n = 0;
    @(posedge MCLK);
    {go, cmd, slow} <= {1'b1, c, 2'($urandom_range(3))};
    @(posedge MCLK);
    go <= 1'b0;
    do @(negedge MCLK); while (busy && ++n < 20);
    if (n >= 20) chk("core", 0, 1);
    repeat (2) @(negedge MCLK);
  endtask : core_do
  function automatic int win();
    int b, bl;
    b = -1;
    bl = 0;
    for (int t = 0; t < 5; t++) if (trp[t]) return t + 1;
    for (int i = 0; i < 72; i++)
      if (flg[i] && pl[i] > bl && pl[i] > clvl && (!tdis || pl[i] == 7)) begin
        b = i + 8;
        bl = pl[i];
      end
    return b;
  endfunction : win
  task automatic step(int show);
    lastv = win();
    core_do(2'h1);
    if (!show) return;
    chk("req", REQ, lastv >= 0);
    if (lastv >= 0) chk("vec", VECTOR, lastv);
    if (lastv >= 0) chk("pri", VEC_ADDR_PRI, 4 + 2 * lastv);
    if (lastv >= 0) chk("alt", VEC_ADDR_ALT, (lastv < 8 ? 'h84 : 'h104) + 2 * lastv);
  endtask : step
  task automatic take();
    core_do(2'h2);
    stk.push_back(clvl);
    if (lastv < 8) trp[lastv-1] = 1'b0;
    else clvl = noff ? 7 : pl[lastv-8];
    chk("lvl", CORE_LVL, clvl);
    chk("drop", REQ, 0);
  endtask : take
  task automatic ret();
    core_do(2'h3);
    clvl = stk.pop_back();
    chk("lvl", CORE_LVL, clvl);
  endtask : ret
  task automatic setp(int i, int l);
    logic [31:0] w;
    pl[i] = l;
    for (int j = 0; j < 8; j++) w[4*j+:4] = 4'(pl[8*(i/8)+j]);
    wb(1'b1, 8'(OFS_PRIO + 4 * (i / 8)), w);
  endtask : setp
  task automatic setf(int i, int hw);
    flg[i] = 1'b1;
    if (hw) begin
      @(posedge MCLK) SRC_EVENT[i] <= 1'b1;
      @(posedge MCLK) SRC_EVENT <= '0;
    end else for (int w = 0; w < 3; w++) wb(1'b1, 8'(OFS_FLAG + 4 * w), 32'(flg >> 32 * w));
  endtask : setf
  task automatic clrf();
    flg = '0;
    for (int w = 0; w < 3; w++) wb(1'b1, 8'(OFS_FLAG + 4 * w), 32'h0);
  endtask : clrf
  initial begin
    #800000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    {RST_N, CYC_I, STB_I, WE_I, ADR_I, DAT_I, go, cmd, slow} = '0;
    {SRC_EVENT, TRAP_EVENT, flg, trp, clvl, noff, tdis} = '0;
    SEL_I = 4'hf;
    void'($urandom(32'h9345));
    repeat (4) @(posedge MCLK);
    RST_N <= 1'b1;
    rd(OFS_CTRL, 0);
    rd(8'hfc, 0);
    step(1);
    for (int w = 0; w < 3; w++) wb(1'b1, 8'(OFS_ENABLE + 4 * w), 32'hffffffff);
    $display("reset test done");
    for (r = 0; r < 6; r++) begin
      for (int n = 0; n < 4; n++) begin
        s = $urandom_range(71);
        setp(s, r[0] ? 5 : $urandom_range(7));
        setf(s, n[0]);
      end
      step(1);
      if (lastv >= 0) take();
      if (lastv >= 0) ret();
      clrf();
    end
    $display("arbitration test done");
    for (s = 0; s < 72; s++) if (pl[s] != 0) setp(s, 0);
    setp(0, 4);
    setp(1, 3);
    setp(2, 5);
    setf(0, 0);
    step(1);
    take();
    setf(1, 1);
    step(1);
    setf(2, 1);
    step(1);
    take();
    ret();
    ret();
    $display("nesting test done");
    wb(1'b1, OFS_CTRL, 32'h8000);
    noff = 1;
    wb(1'b1, OFS_MASK, 32'h4);
    rd(OFS_MASK, 32'h4);
    wb(1'b1, OFS_CORE_LVL, 32'h3);
    rd(OFS_CORE_LVL, 0);
    chk("irq", INT_O, 1);
    wb(1'b1, OFS_STATUS, 32'h4);
    repeat (2) @(negedge MCLK);
    chk("irq", INT_O, 0);
    step(1);
    take();
    setp(3, 6);
    setf(3, 0);
    step(1);
    ret();
    wb(1'b1, OFS_CTRL, 32'h0);
    noff = 0;
    $display("nest off test done");
    @(posedge MCLK) TRAP_EVENT <= 5'h1f;
    @(posedge MCLK) TRAP_EVENT <= 5'h0;
    trp = 5'h1f;
    rd(OFS_TRAP, 32'h1f);
    rd(OFS_STATUS, 32'h1);
    wb(1'b1, OFS_STATUS, 32'h1);
    for (k = 0; k < 5; k++) begin
      step(1);
      take();
    end
    $display("trap test done");
    clrf();
    setf(2, 0);
    setp(3, 7);
    wb(1'b1, OFS_TDIS, 32'h3);
    tdis = 1;
    rd(OFS_TDIS, 32'h10003);
    step(1);
    setf(3, 1);
    step(1);
    take();
    ret();
    step(0);
    tdis = 0;
    rd(OFS_TDIS, 0);
    rd(OFS_STATUS, 32'h2);
    flg[3] = 1'b0;
    wb(1'b1, OFS_FLAG, 32'(flg));
    step(1);
    rd(8'(OFS_PRIO), 32'h7534);
    rd(8'(OFS_FLAG), 32'h4);
    wb(1'b1, 8'(OFS_ENABLE), 32'h0);
    core_do(2'h1);
    chk("req", REQ, 0);
    rd(8'(OFS_ENABLE), 0);
    $display("timed disable test done");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
